// ===== rtl/rsrh_server.sv
// Request decoder and reply builder of the RTU server front end
// How it works
// - One reply per accepted request; new requests are ignored while replying.
// - Frames longer than 256 bytes are marked oversize and dropped.
// - Reply payload kept within 253 bytes; reads over 125 registers refused.
// - Read reply sent as address, function, byte count, register pairs, check.
// - Each field is one byte; 16-bit values travel as two bytes.
// - Only read holding, read input and preset single are served.
// - Holding read returns meter variables and echoes the function code.
// - Holding register zero is flow low half, register one flow high half.
`timescale 1ns/100ps
`default_nettype none
module rsrh_server (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] server_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_end,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] mass_flow,
  output logic [15:0] var_addr,
  output logic var_input_space,
  input wire logic [15:0] var_rdata,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  output logic busy,
  output logic frame_dropped
);

  // Receive side state
  logic [7:0] rx_buf_q [rsrh_pkg::REQ_LEN];
  logic [8:0] rx_cnt_q;
  logic rx_oversize_q;
  logic [15:0] rx_crc_q;

  // Reply side state
  rsrh_pkg::rsrh_state_e state_q;
  logic [7:0] fc_q;
  logic [7:0] resp_fc_q;
  logic [7:0] exc_code_q;
  logic is_write_q;
  logic [15:0] start_q;
  logic [15:0] value_q;
  logic [15:0] cur_reg_q;
  logic [6:0] remain_q;
  logic [1:0] echo_idx_q;
  logic [15:0] word_q;
  logic [15:0] tx_crc_q;
  logic [15:0] var_addr_q;
  logic var_input_space_q;
  logic wr_valid_q;
  logic [15:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic busy_q;
  logic frame_dropped_q;
  logic [7:0] tx_data_q;
  logic tx_valid_q;

  // Buffer ports
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;

  // Request field decode
  wire [7:0] req_fc = rx_buf_q[rsrh_pkg::POS_FC];
  wire [15:0] req_start = {rx_buf_q[rsrh_pkg::POS_START_HI], rx_buf_q[rsrh_pkg::POS_START_LO]};
  wire [15:0] req_count = {rx_buf_q[rsrh_pkg::POS_COUNT_HI], rx_buf_q[rsrh_pkg::POS_COUNT_LO]};
  wire [15:0] req_crc = {rx_buf_q[rsrh_pkg::POS_CRC_HI], rx_buf_q[rsrh_pkg::POS_CRC_LO]};
  wire len_ok = (rx_cnt_q == {5'h00, rsrh_pkg::REQ_LEN}) && !rx_oversize_q;
  wire addr_ok = (rx_buf_q[rsrh_pkg::POS_ADDR] == server_addr);
  wire crc_ok = (rx_crc_q == req_crc);
  wire frame_ok = len_ok && addr_ok && crc_ok;
  wire take_frame = rx_end && (state_q == rsrh_pkg::S_IDLE);
  wire fc_read = (req_fc == rsrh_pkg::FC_READ_HOLDING) || (req_fc == rsrh_pkg::FC_READ_INPUT);
  wire fc_write = (req_fc == rsrh_pkg::FC_PRESET_SINGLE);
  wire count_bad = (req_count == 16'h0000) || (req_count > {9'h000, rsrh_pkg::MAX_READ_REGS});
  wire [8:0] pdu_len = 9'h002 + {1'b0, req_count[6:0], 1'b0};

  // Register word selection: flow halves come from the meter input
  wire holding = (fc_q == rsrh_pkg::FC_READ_HOLDING);
  wire sel_flow_lo = holding && (cur_reg_q == rsrh_pkg::REG_FLOW_LOW);
  wire sel_flow_hi = holding && (cur_reg_q == rsrh_pkg::REG_FLOW_HIGH);
  wire [15:0] read_word = sel_flow_lo ? mass_flow[15:0] :
                          sel_flow_hi ? mass_flow[31:16] : var_rdata;

  // Byte offered to the reply buffer in each state
  logic emit_valid;
  logic [7:0] emit_byte;
  always_comb begin
    emit_valid = 1'b1;
    emit_byte = 8'h00;
    case (state_q)
      rsrh_pkg::S_ADDR: emit_byte = server_addr;
      rsrh_pkg::S_FC: emit_byte = resp_fc_q;
      rsrh_pkg::S_EXC: emit_byte = exc_code_q;
      rsrh_pkg::S_ECHO: begin
        case (echo_idx_q)
          2'h0: emit_byte = start_q[15:8];
          2'h1: emit_byte = start_q[7:0];
          2'h2: emit_byte = value_q[15:8];
          default: emit_byte = value_q[7:0];
        endcase
      end
      rsrh_pkg::S_BCNT: emit_byte = {remain_q, 1'b0};
      rsrh_pkg::S_RD_HI: emit_byte = word_q[15:8];
      rsrh_pkg::S_RD_LO: emit_byte = word_q[7:0];
      rsrh_pkg::S_CRC_HI: emit_byte = tx_crc_q[15:8];
      rsrh_pkg::S_CRC_LO: emit_byte = tx_crc_q[7:0];
      default: emit_valid = 1'b0;
    endcase
  end
  wire emit_go = emit_valid && fifo_in_ready;

  // Request collection: bytes, length and running check
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < int'(rsrh_pkg::REQ_LEN); i++) begin
        rx_buf_q[i] <= 8'h00;
      end
      rx_cnt_q <= 9'h000;
      rx_oversize_q <= 1'b0;
      rx_crc_q <= rsrh_pkg::CRC_INIT;
    end else if (rx_end) begin
      rx_cnt_q <= 9'h000;
      rx_oversize_q <= 1'b0;
      rx_crc_q <= rsrh_pkg::CRC_INIT;
    end else if (rx_valid) begin
      if (rx_cnt_q < {5'h00, rsrh_pkg::REQ_LEN}) begin
        rx_buf_q[rx_cnt_q[2:0]] <= rx_data;
      end
      if (rx_cnt_q < {5'h00, rsrh_pkg::CRC_SPAN}) begin
        rx_crc_q <= rsrh_pkg::crc_step(rx_crc_q, rx_data);
      end
      if (rx_cnt_q == rsrh_pkg::ADU_MAX) begin
        rx_oversize_q <= 1'b1;
      end else begin
        rx_cnt_q <= rx_cnt_q + 9'h001;
      end
    end
  end

  // Reply sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rsrh_pkg::S_IDLE;
      fc_q <= 8'h00;
      resp_fc_q <= 8'h00;
      exc_code_q <= 8'h00;
      is_write_q <= 1'b0;
      start_q <= 16'h0000;
      value_q <= 16'h0000;
      cur_reg_q <= 16'h0000;
      remain_q <= 7'h00;
      echo_idx_q <= 2'h0;
      word_q <= 16'h0000;
    end else begin
      case (state_q)
        rsrh_pkg::S_IDLE: begin
          if (take_frame && frame_ok) begin
            fc_q <= req_fc;
            start_q <= req_start;
            value_q <= req_count;
            cur_reg_q <= req_start;
            remain_q <= req_count[6:0];
            echo_idx_q <= 2'h0;
            is_write_q <= fc_write;
            state_q <= rsrh_pkg::S_ADDR;
            if (!(fc_read || fc_write)) begin
              resp_fc_q <= req_fc | rsrh_pkg::EXC_FLAG;
              exc_code_q <= rsrh_pkg::EXC_ILLEGAL_FUNCTION;
            end else if (fc_read && (count_bad || pdu_len > rsrh_pkg::PDU_MAX)) begin
              resp_fc_q <= req_fc | rsrh_pkg::EXC_FLAG;
              exc_code_q <= rsrh_pkg::EXC_ILLEGAL_VALUE;
            end else begin
              resp_fc_q <= req_fc;
              exc_code_q <= 8'h00;
            end
          end
        end
        rsrh_pkg::S_ADDR: if (emit_go) begin
          state_q <= rsrh_pkg::S_FC;
        end
        rsrh_pkg::S_FC: if (emit_go) begin
          if (resp_fc_q[7]) begin
            state_q <= rsrh_pkg::S_EXC;
          end else if (is_write_q) begin
            state_q <= rsrh_pkg::S_ECHO;
          end else begin
            state_q <= rsrh_pkg::S_BCNT;
          end
        end
        rsrh_pkg::S_EXC: if (emit_go) begin
          state_q <= rsrh_pkg::S_CRC_HI;
        end
        rsrh_pkg::S_ECHO: if (emit_go) begin
          echo_idx_q <= echo_idx_q + 2'h1;
          if (echo_idx_q == 2'h3) begin
            state_q <= rsrh_pkg::S_CRC_HI;
          end
        end
        rsrh_pkg::S_BCNT: if (emit_go) begin
          state_q <= rsrh_pkg::S_RD_REQ;
        end
        rsrh_pkg::S_RD_REQ: state_q <= rsrh_pkg::S_RD_LATCH;
        rsrh_pkg::S_RD_LATCH: begin
          word_q <= read_word;
          state_q <= rsrh_pkg::S_RD_HI;
        end
        rsrh_pkg::S_RD_HI: if (emit_go) begin
          state_q <= rsrh_pkg::S_RD_LO;
        end
        rsrh_pkg::S_RD_LO: if (emit_go) begin
          cur_reg_q <= cur_reg_q + 16'h0001;
          remain_q <= remain_q - 7'h01;
          state_q <= (remain_q == 7'h01) ? rsrh_pkg::S_CRC_HI : rsrh_pkg::S_RD_REQ;
        end
        rsrh_pkg::S_CRC_HI: if (emit_go) begin
          state_q <= rsrh_pkg::S_CRC_LO;
        end
        rsrh_pkg::S_CRC_LO: if (emit_go) begin
          state_q <= rsrh_pkg::S_IDLE;
        end
        default: state_q <= rsrh_pkg::S_IDLE;
      endcase
    end
  end

  // Reply check, variable port, write strobe and status flags
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_crc_q <= rsrh_pkg::CRC_INIT;
      var_addr_q <= 16'h0000;
      var_input_space_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      busy_q <= 1'b0;
      frame_dropped_q <= 1'b0;
    end else begin
      wr_valid_q <= 1'b0;
      frame_dropped_q <= take_frame && !frame_ok;
      busy_q <= (state_q != rsrh_pkg::S_IDLE);
      if (state_q == rsrh_pkg::S_IDLE) begin
        tx_crc_q <= rsrh_pkg::CRC_INIT;
      end else if (emit_go && state_q != rsrh_pkg::S_CRC_HI && state_q != rsrh_pkg::S_CRC_LO) begin
        tx_crc_q <= rsrh_pkg::crc_step(tx_crc_q, emit_byte);
      end
      if (state_q == rsrh_pkg::S_RD_REQ) begin
        var_addr_q <= cur_reg_q;
        var_input_space_q <= (fc_q == rsrh_pkg::FC_READ_INPUT);
      end
      if (take_frame && frame_ok && fc_write) begin
        wr_valid_q <= 1'b1;
        wr_addr_q <= req_start;
        wr_data_q <= req_count;
      end
    end
  end

  // Output stage so the link sees flip-flop outputs
  assign fifo_out_ready = !tx_valid_q || tx_ready;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else if (fifo_out_ready) begin
      tx_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_data_q <= fifo_out_data;
      end
    end
  end

  // Reply buffer between sequencer and link
  rsrh_fifo #(
    .WIDTH(rsrh_pkg::FIFO_WIDTH),
    .DEPTH(rsrh_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(emit_valid),
    .in_ready(fifo_in_ready),
    .in_data(emit_byte),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign var_addr = var_addr_q;
  assign var_input_space = var_input_space_q;
  assign wr_valid = wr_valid_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign busy = busy_q;
  assign frame_dropped = frame_dropped_q;

endmodule : rsrh_server
`default_nettype wire

// ===== rtl/rsrh_pkg.sv
// Shared constants and the frame check function of the RTU request handler
package rsrh_pkg;

  // Frame size limits
  localparam logic [8:0] ADU_MAX = 9'h100;   // Whole serial frame, bytes
  localparam logic [8:0] PDU_MAX = 9'h0FD;   // Function code and payload, bytes
  localparam logic [3:0] REQ_LEN = 4'h8;     // Every accepted request is eight bytes
  localparam logic [3:0] CRC_SPAN = 4'h6;    // Bytes covered by the frame check
  localparam logic [6:0] MAX_READ_REGS = 7'h7D; // Register pairs that fit in one reply

  // Request byte positions
  localparam int unsigned POS_ADDR = 0;
  localparam int unsigned POS_FC = 1;
  localparam int unsigned POS_START_HI = 2;
  localparam int unsigned POS_START_LO = 3;
  localparam int unsigned POS_COUNT_HI = 4;
  localparam int unsigned POS_COUNT_LO = 5;
  localparam int unsigned POS_CRC_HI = 6;
  localparam int unsigned POS_CRC_LO = 7;

  // Function codes and exception answers
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_PRESET_SINGLE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // Meter registers served from the flow input
  localparam logic [15:0] REG_FLOW_LOW = 16'h0000;
  localparam logic [15:0] REG_FLOW_HIGH = 16'h0001;

  // Frame check polynomial, reflected form
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // Response buffer shape
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_FC, S_EXC, S_ECHO, S_BCNT, S_RD_REQ, S_RD_LATCH,
    S_RD_HI, S_RD_LO, S_CRC_HI, S_CRC_LO
  } rsrh_state_e;

  // Folds one byte into the running frame check
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

endpackage : rsrh_pkg

// ===== rtl/rsrh_fifo.sv
// Byte FIFO with valid and ready on both sides for the reply stream
`timescale 1ns/100ps
`default_nettype none
module rsrh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push;
  wire pop;

  // Full and empty come from the fill count, which is one bit wider than a pointer
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : rsrh_fifo
`default_nettype wire

// ===== verification/rsrh_checker.sv
// Port checker of the RTU request handler
`timescale 1ns/100ps
`default_nettype none
module rsrh_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] server_addr,
  input wire logic rx_end,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic wr_valid,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic busy,
  input wire logic frame_dropped
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Reply start and its opening byte
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_addr_out;
    ##[0:4] (tx_valid && tx_data == server_addr);
  endsequence
  AST_FIRST_BYTE: assert property (s_start |-> s_addr_out)
    else $error("reply does not open with own address");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(rx_end) || $past(rx_end, 2))
    else $error("reply started without a frame end");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte lost before taken");
  AST_DROP_CAUSE: assert property (frame_dropped |-> $past(rx_end))
    else $error("drop without frame end");
  AST_DROP_QUIET: assert property (frame_dropped |=> !busy [*3])
    else $error("dropped frame got a reply");
  AST_DROP_IDLE: assert property (busy |-> !frame_dropped)
    else $error("frame dropped while replying");
  AST_WR_CAUSE: assert property (wr_valid |-> $past(rx_end) || $past(rx_end, 2))
    else $error("preset without frame end");
  AST_WR_HOLD: assert property (!$stable(wr_addr) || !$stable(wr_data) |-> wr_valid)
    else $error("preset value moved without pulse");
endmodule : rsrh_checker
bind rsrh_server rsrh_checker chk_u (.mclk(mclk), .reset_n(reset_n),
  .server_addr(server_addr), .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
  .busy(busy), .frame_dropped(frame_dropped));
`default_nettype wire

// ===== verification/rsrh_client.sv
// Serial client model that sends request frames and takes replies
`timescale 1ns/100ps
`default_nettype none
module rsrh_client (
  input wire logic mclk,
  input wire logic stall,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_end,
  output logic tx_ready
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
  end
  // Reply bytes are taken unless the bench stalls
  assign tx_ready = !stall;
  // Sends one whole frame byte by byte, then the gap marker
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge mclk);
      #1;
      rx_data = f[i];
      rx_valid = 1'b1;
    end
    @(posedge mclk);
    #1;
    rx_data = ~rx_data; // Released line shows no stale byte
    rx_valid = 1'b0;
    rx_end = 1'b1;
    @(posedge mclk);
    #1;
    rx_end = 1'b0;
  endtask : send
endmodule : rsrh_client
`default_nettype wire

// ===== verification/rsrh_server_test.sv
// Self-checking bench of the RTU request handler
`timescale 1ns/100ps
`default_nettype none
module rsrh_server_test;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] server_addr = 8'h2D;
  logic [31:0] mass_flow = 32'h00000000;
  logic stall = 1'b0;
  logic slow = 1'b0;
  wire logic [7:0] rx_data, tx_data;
  wire logic rx_valid, rx_end, tx_valid, tx_ready, var_input_space, wr_valid, busy, frame_dropped;
  wire logic [15:0] var_addr, var_rdata, wr_addr, wr_data;
  logic [7:0] exp_q[$], f[$], r[$];
  logic [31:0] wr_q[$];
  logic [15:0] v;
  logic [7:0] xf[3] = '{8'h10, 8'h04, 8'h03};
  logic [15:0] xn[3] = '{16'h0001, 16'h0000, 16'h007E};
  logic [7:0] xc[3] = '{8'h01, 8'h03, 8'h03};
  int bad_count = 0, comparisons = 0, drops = 0, seed = 63945;
  rsrh_server dut_u (.mclk(mclk), .reset_n(reset_n), .server_addr(server_addr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .mass_flow(mass_flow), .var_addr(var_addr),
    .var_input_space(var_input_space), .var_rdata(var_rdata), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy), .frame_dropped(frame_dropped));
  rsrh_client cli_u (.mclk(mclk), .stall(stall), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_end(rx_end), .tx_ready(tx_ready));
  // Clock and meter variable source
  always #5 mclk = ~mclk;
  assign var_rdata = var_addr ^ (var_input_space ? 16'h5A3C : 16'hC3A5); // Space shows in data
  // Random back-pressure while slow is set
  always @(posedge mclk) begin
    #1;
    stall = slow && (($random(seed) & 3) != 0);
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // Builds and sends a request, optionally with a broken check
  task automatic req(input logic [7:0] adr, fc, input logic [15:0] a, b, input logic bad);
    logic [15:0] c;
    f = '{adr, fc, a[15:8], a[7:0], b[15:8], b[7:0]};
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    cli_u.send(f);
  endtask : req
  // Notes an expected reply with its check bytes
  task automatic expect_reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    foreach (q[i]) exp_q.push_back(q[i]);
  endtask : expect_reply
  // Waits for the reply to drain, bounded
  task automatic settle(input string name);
    int n;
    n = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0) && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    repeat (8) @(posedge mclk);
    $display("test %s done", name);
    if (n == 4000) begin
      bad_count++;
      $display("unexpected at %0t: reply wait ran out", $time);
      print_verdict();
    end
  endtask : settle
  // Output watcher takes the oldest note for each result
  always @(posedge mclk) begin
    if (frame_dropped === 1'b1) drops++;
    if (wr_valid === 1'b1) check({wr_addr, wr_data}, wr_q.pop_front());
    if (tx_valid === 1'b1 && tx_ready) begin
      if (exp_q.size() == 0) check(32'h00000100, 32'h00000000);
      else check({24'h000000, tx_data}, {24'h000000, exp_q.pop_front()});
    end
  end
  initial begin
    mass_flow = $random(seed);
    repeat (8) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    slow = 1'b1;
    expect_reply('{8'h2D, 8'h03, 8'h04, mass_flow[15:8], mass_flow[7:0],
      mass_flow[31:24], mass_flow[23:16]});
    req(8'h2D, 8'h03, 16'h0000, 16'h0002, 1'b0);
    settle("holding flow");
    r = '{8'h2D, 8'h04, 8'hFA};
    for (int i = 0; i < 125; i++) begin
      v = (16'h0100 + i[15:0]) ^ 16'h5A3C;
      r.push_back(v[15:8]);
      r.push_back(v[7:0]);
    end
    expect_reply(r);
    req(8'h2D, 8'h04, 16'h0100, 16'h007D, 1'b0);
    settle("input max");
    slow = 1'b0;
    foreach (xf[i]) begin
      expect_reply('{8'h2D, xf[i] | 8'h80, xc[i]});
      req(8'h2D, xf[i], 16'h0000, xn[i], 1'b0);
      settle("exception");
    end
    wr_q.push_back(32'h0042BEEF);
    expect_reply('{8'h2D, 8'h06, 8'h00, 8'h42, 8'hBE, 8'hEF});
    req(8'h2D, 8'h06, 16'h0042, 16'hBEEF, 1'b0);
    settle("preset");
    // Three registers keep the reply running while the second request ends
    expect_reply('{8'h2D, 8'h03, 8'h06, mass_flow[31:24], mass_flow[23:16],
      8'hC3, 8'hA7, 8'hC3, 8'hA6});
    req(8'h2D, 8'h03, 16'h0001, 16'h0003, 1'b0);
    req(8'h2D, 8'h03, 16'h0001, 16'h0003, 1'b0);
    settle("back to back");
    check(drops, 32'h00000000);
    req(8'h2E, 8'h03, 16'h0000, 16'h0001, 1'b0);
    req(8'h2D, 8'h03, 16'h0000, 16'h0001, 1'b1);
    f = {};
    for (int i = 0; i < 257; i++) f.push_back($random(seed));
    cli_u.send(f);
    settle("drops");
    check(drops, 32'h00000003);
    print_verdict();
  end
endmodule : rsrh_server_test
`default_nettype wire
